// ===== lsb_cfg.svh
`ifndef LSB_CFG_SVH
`define LSB_CFG_SVH

// clock and times
`define LSB_CLK_MHZ          100
`define LSB_BLINK_HALF_MS    500
`define LSB_TICK_MS          10
`define LSB_BLINK_HALF_CYC   (`LSB_BLINK_HALF_MS * 1000 * `LSB_CLK_MHZ)
`define LSB_TICK_CYC         (`LSB_TICK_MS * 1000 * `LSB_CLK_MHZ)

// counts
`define LSB_AUX_BITS         63
`define LSB_NUM_TMR          31
`define LSB_NUM_CNT          31
`define LSB_NUM_OS           16
`define LSB_NUM_EXT          8
`define LSB_PRESET_MAX       16'h270F
`define LSB_PRESET_MIN       16'h0000

// special bit positions in the first bank (bit i is auxiliary i+1)
`define LSB_FS_BIT           48
`define LSB_BLINK_BIT        49
`define LSB_SUMMER_BIT       50
`define LSB_THERMO_BIT       51

// preset config word fields
`define LSB_CFG_SRC_LSB      16
`define LSB_CFG_IDX_LSB      18
`define LSB_CFG_RST          24'h000000

// register offsets
`define LSB_REG_M_LO         12'h000
`define LSB_REG_M_HI         12'h004
`define LSB_REG_N_LO         12'h008
`define LSB_REG_N_HI         12'h00C
`define LSB_REG_TSTAT        12'h010
`define LSB_REG_CSTAT        12'h014
`define LSB_REG_SYS          12'h018
`define LSB_REG_TCFG         12'h100
`define LSB_REG_CCFG         12'h200
`define LSB_REG_TCUR         12'h300
`define LSB_REG_CCUR         12'h380

`endif

// ===== lsb_pkg.sv
package lsb_pkg;

    // phase after power-up, one-hot
    typedef enum logic [1:0] {
        LSB_ST_RESTORE = 2'h1,
        LSB_ST_RUN     = 2'h2
    } lsb_phase_t;

    // preset source selector
    typedef enum logic [1:0] {
        LSB_SRC_CONST = 2'h0,
        LSB_SRC_TMR   = 2'h1,
        LSB_SRC_CNT   = 2'h2,
        LSB_SRC_EXT   = 2'h3
    } lsb_src_t;

    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } lsb_bus_t;

    // coil drive of one auxiliary bank for the current scan
    typedef struct packed {
        logic [62:0] out_en;
        logic [62:0] out_val;
        logic [62:0] set;
        logic [62:0] rst;
        logic [62:0] tgl;
    } lsb_coil_t;

endpackage

// ===== lsb_scan_bits.sv
`timescale 1ns/1ps
`include "lsb_cfg.svh"

module lsb_scan_bits
    import lsb_pkg::*;
#(
    parameter int          NUM_TMR        = `LSB_NUM_TMR,
    parameter int          NUM_CNT        = `LSB_NUM_CNT,
    parameter int          NUM_OS         = `LSB_NUM_OS,
    parameter int          NUM_EXT        = `LSB_NUM_EXT,
    parameter logic [15:0] PRESET_MAX     = `LSB_PRESET_MAX,
    parameter logic [15:0] PRESET_MIN     = `LSB_PRESET_MIN,
    parameter logic [31:0] BLINK_HALF_CYC = `LSB_BLINK_HALF_CYC,
    parameter logic [31:0] TICK_CYC       = `LSB_TICK_CYC
) (
    input  wire logic                      mclk_in,
    input  wire logic                      sys_rst_in,
    input  wire lsb_bus_t                  bus_in,
    output logic [31:0]                    rdata_out,
    input  wire logic                      scan_in,
    input  wire logic                      keep_opt_in,
    input  wire logic [62:0]               nv_image_in,
    input  wire lsb_coil_t                 m_coil_in,
    input  wire lsb_coil_t                 n_coil_in,
    input  wire logic [NUM_OS-1:0]         os_in,
    output logic [NUM_OS-1:0]              rise_out,
    output logic [NUM_OS-1:0]              fall_out,
    input  wire logic [NUM_TMR-1:0]        tmr_en_in,
    input  wire logic [NUM_CNT-1:0]        cnt_in,
    input  wire logic [NUM_CNT-1:0]        cnt_dir_in,
    input  wire logic [NUM_CNT-1:0]        cnt_rst_in,
    input  wire logic [NUM_EXT-1:0][15:0]  ext_val_in,
    input  wire logic                      summer_in,
    input  wire logic [3:0]                thermo_err_in,
    output logic [62:0]                    m_bank_out,
    output logic [62:0]                    n_bank_out,
    output logic [NUM_TMR-1:0]             tmr_stat_out,
    output logic [NUM_CNT-1:0]             cnt_stat_out
);

    // refuse sizes that the status words and index fields cannot hold
    if (NUM_TMR < 1 || NUM_TMR > 32 || NUM_CNT < 1 || NUM_CNT > 32) begin : g_chk_fn
        $error("timer and counter counts must be 1..32");
    end
    if (NUM_OS < 1 || NUM_EXT < 1 || NUM_EXT > 64 || BLINK_HALF_CYC < 1 || TICK_CYC < 1) begin : g_chk_misc
        $error("one-shot, source or divider setting out of range");
    end

    typedef struct packed {
        lsb_phase_t                  phase;
        logic                        fs_pend;
        logic [62:0]                 mb;
        logic [62:0]                 nb;
        logic [1:0][2:0][62:0]       eprev;
        logic [NUM_OS-1:0]           os_prev;
        logic [NUM_OS-1:0]           rise;
        logic [NUM_OS-1:0]           fall;
        logic [NUM_TMR-1:0][15:0]    tcur;
        logic [NUM_TMR-1:0][23:0]    tcfg;
        logic [NUM_TMR-1:0]          tstat;
        logic [NUM_CNT-1:0][15:0]    ccur;
        logic [NUM_CNT-1:0][23:0]    ccfg;
        logic [NUM_CNT-1:0]          cin_prev;
        logic [NUM_CNT-1:0]          cstat;
        logic [31:0]                 bdiv;
        logic [31:0]                 tdiv;
        logic                        blink;
        logic                        tick_pend;
        logic                        summer_prev;
        logic [31:0]                 rdata;
    } lsb_state_t;

    lsb_state_t                 r;
    lsb_state_t                 next_r;
    logic [NUM_TMR-1:0][15:0]   tpre;
    logic [NUM_CNT-1:0][15:0]   cpre;

    // resolve a preset from its source and clamp it into the legal range
    function automatic logic [15:0] eff_preset(input logic [23:0]              cfg,
                                               input logic [NUM_TMR-1:0][15:0] tc,
                                               input logic [NUM_CNT-1:0][15:0] cc,
                                               input logic [NUM_EXT-1:0][15:0] ev);
        logic [15:0] raw;
        logic [5:0]  idx;
        raw = cfg[15:0];
        idx = cfg[`LSB_CFG_IDX_LSB +: 6];
        case (lsb_src_t'(cfg[`LSB_CFG_SRC_LSB +: 2]))
            LSB_SRC_TMR: begin
                if (int'(idx) < NUM_TMR) raw = tc[idx];
            end
            LSB_SRC_CNT: begin
                if (int'(idx) < NUM_CNT) raw = cc[idx];
            end
            LSB_SRC_EXT: begin
                if (int'(idx) < NUM_EXT) raw = ev[idx];
            end
            default: begin
                raw = cfg[15:0];
            end
        endcase
        if (raw > PRESET_MAX) raw = PRESET_MAX;
        if (raw < PRESET_MIN) raw = PRESET_MIN;
        return raw;
    endfunction

    // coil instructions of one bank; reset is applied last so it wins a same-scan clash
    function automatic logic [62:0] coil_eval(input logic [62:0]      cur,
                                              input lsb_coil_t        c,
                                              input logic [2:0][62:0] prev);
        logic [62:0] v;
        v = (cur & ~c.out_en) | (c.out_val & c.out_en);
        v = v | (c.set & ~prev[0]);
        v = v ^ (c.tgl & ~prev[2]);
        v = v & ~(c.rst & ~prev[1]);
        return v;
    endfunction

    // effective presets, recomputed every cycle from the live current values
    always_comb begin
        for (int i = 0; i < NUM_TMR; i++) begin
            tpre[i] = eff_preset(r.tcfg[i], r.tcur, r.ccur, ext_val_in);
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            cpre[i] = eff_preset(r.ccfg[i], r.tcur, r.ccur, ext_val_in);
        end
    end

    // whole next state; reset is synchronous so it is folded in here
    always_comb begin
        next_r = r;
        // free-running dividers keep the blink independent of scan rate
        if (r.bdiv >= BLINK_HALF_CYC - 32'h1) begin
            next_r.bdiv  = 32'h0;
            next_r.blink = ~r.blink;
        end else begin
            next_r.bdiv = r.bdiv + 32'h1;
        end
        if (r.tdiv >= TICK_CYC - 32'h1) begin
            next_r.tdiv = 32'h0;
        end else begin
            next_r.tdiv = r.tdiv + 32'h1;
        end
        // a tick landing on the consuming scan is kept, not lost
        next_r.tick_pend = (r.tick_pend & ~(scan_in && r.phase == LSB_ST_RUN)) | (r.tdiv >= TICK_CYC - 32'h1);

        // status compares run every cycle
        for (int i = 0; i < NUM_TMR; i++) begin
            next_r.tstat[i] = (r.tcur[i] >= tpre[i]);
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            next_r.cstat[i] = (r.ccur[i] >= cpre[i]);
        end

        // register port: writes reach the preset config words only
        next_r.rdata = 32'h0;
        for (int i = 0; i < NUM_TMR; i++) begin
            if (bus_in.wr && bus_in.addr == 12'(`LSB_REG_TCFG + 4 * i)) next_r.tcfg[i] = bus_in.wdata[23:0];
            if (bus_in.rd && bus_in.addr == 12'(`LSB_REG_TCFG + 4 * i)) next_r.rdata = {8'h0, r.tcfg[i]};
            if (bus_in.rd && bus_in.addr == 12'(`LSB_REG_TCUR + 4 * i)) next_r.rdata = {16'h0, r.tcur[i]};
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            if (bus_in.wr && bus_in.addr == 12'(`LSB_REG_CCFG + 4 * i)) next_r.ccfg[i] = bus_in.wdata[23:0];
            if (bus_in.rd && bus_in.addr == 12'(`LSB_REG_CCFG + 4 * i)) next_r.rdata = {8'h0, r.ccfg[i]};
            if (bus_in.rd && bus_in.addr == 12'(`LSB_REG_CCUR + 4 * i)) next_r.rdata = {16'h0, r.ccur[i]};
        end
        if (bus_in.rd) begin
            case (bus_in.addr)
                `LSB_REG_M_LO:  next_r.rdata = r.mb[31:0];
                `LSB_REG_M_HI:  next_r.rdata = {1'b0, r.mb[62:32]};
                `LSB_REG_N_LO:  next_r.rdata = r.nb[31:0];
                `LSB_REG_N_HI:  next_r.rdata = {1'b0, r.nb[62:32]};
                `LSB_REG_TSTAT: next_r.rdata = 32'(r.tstat);
                `LSB_REG_CSTAT: next_r.rdata = 32'(r.cstat);
                `LSB_REG_SYS:   next_r.rdata = {29'h0, r.fs_pend, r.blink, r.phase == LSB_ST_RUN};
                default:        next_r.rdata = next_r.rdata;
            endcase
        end

        case (r.phase)
            LSB_ST_RESTORE: begin
                // strap is caught one edge after reset release, never by the reset itself
                next_r.mb = keep_opt_in ? nv_image_in : 63'h0;
                next_r.mb[`LSB_FS_BIT] = 1'b1;
                next_r.mb[`LSB_SUMMER_BIT] = summer_in;
                next_r.summer_prev = summer_in;
                next_r.fs_pend = 1'b1;
                next_r.phase = LSB_ST_RUN;
            end
            LSB_ST_RUN: begin
                if (scan_in) begin
                    // first-scan flag becomes an ordinary bit once its scan is over
                    next_r.mb = r.mb;
                    if (r.fs_pend) next_r.mb[`LSB_FS_BIT] = 1'b0;
                    next_r.fs_pend = 1'b0;
                    next_r.mb = coil_eval(next_r.mb, m_coil_in, r.eprev[0]);
                    next_r.nb = coil_eval(r.nb, n_coil_in, r.eprev[1]);
                    next_r.eprev[0] = {m_coil_in.tgl, m_coil_in.rst, m_coil_in.set};
                    next_r.eprev[1] = {n_coil_in.tgl, n_coil_in.rst, n_coil_in.set};
                    // system flags take their values for the coming scan
                    next_r.mb[`LSB_BLINK_BIT] = r.blink;
                    if (summer_in != r.summer_prev) next_r.mb[`LSB_SUMMER_BIT] = summer_in;
                    next_r.summer_prev = summer_in;
                    next_r.mb[`LSB_THERMO_BIT +: 4] = thermo_err_in;
                    // one-shots hold for exactly the next scan
                    next_r.rise = os_in & ~r.os_prev;
                    next_r.fall = ~os_in & r.os_prev;
                    next_r.os_prev = os_in;
                    for (int i = 0; i < NUM_TMR; i++) begin
                        if (!tmr_en_in[i]) begin
                            next_r.tcur[i] = 16'h0;
                        end else if (r.tick_pend && r.tcur[i] < tpre[i]) begin
                            next_r.tcur[i] = r.tcur[i] + 16'h1;
                        end
                    end
                    for (int i = 0; i < NUM_CNT; i++) begin
                        if (cnt_rst_in[i]) begin
                            next_r.ccur[i] = 16'h0;
                        end else if (cnt_in[i] && !r.cin_prev[i]) begin
                            if (cnt_dir_in[i]) begin
                                if (r.ccur[i] != 16'h0) next_r.ccur[i] = r.ccur[i] - 16'h1;
                            end else if (r.ccur[i] != 16'hFFFF) begin
                                next_r.ccur[i] = r.ccur[i] + 16'h1;
                            end
                        end
                    end
                    next_r.cin_prev = cnt_in;
                end
            end
            default: begin
                next_r.phase = LSB_ST_RESTORE;
            end
        endcase

        if (sys_rst_in) begin
            next_r = '0;
            next_r.phase = LSB_ST_RESTORE;
            for (int i = 0; i < NUM_TMR; i++) next_r.tcfg[i] = `LSB_CFG_RST;
            for (int i = 0; i < NUM_CNT; i++) next_r.ccfg[i] = `LSB_CFG_RST;
        end
    end

    // single state register
    always_ff @(posedge mclk_in) begin
        r <= next_r;
    end

    assign rdata_out    = r.rdata;
    assign rise_out     = r.rise;
    assign fall_out     = r.fall;
    assign m_bank_out   = r.mb;
    assign n_bank_out   = r.nb;
    assign tmr_stat_out = r.tstat;
    assign cnt_stat_out = r.cstat;

    // timer, counter and coil checks watch element 0 / bit 0, as do the one-shot edge checks; the other elements share the same logic
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    logic scan_run;
    assign scan_run = scan_in && r.phase == LSB_ST_RUN;

    property p_rise;
        scan_run && os_in[0] && !r.os_prev[0] |=> rise_out[0] ##1 (rise_out[0] || $past(scan_in));
    endproperty
    a_rise: assert property (p_rise) else $error("rising one-shot missed");

    property p_fall;
        scan_run && !os_in[0] && r.os_prev[0] |=> fall_out[0] && !rise_out[0];
    endproperty
    a_fall: assert property (p_fall) else $error("falling one-shot missed");

    property p_set;
        scan_run && m_coil_in.set[0] && !r.eprev[0][0][0] && !m_coil_in.rst[0] |=> m_bank_out[0];
    endproperty
    a_set: assert property (p_set) else $error("set coil not latched");

    property p_reset;
        scan_run && n_coil_in.rst[0] && !r.eprev[1][1][0] |=> !n_bank_out[0];
    endproperty
    a_reset: assert property (p_reset) else $error("reset coil not cleared");

    property p_toggle;
        scan_run && m_coil_in.tgl[0] && !r.eprev[0][2][0] && !m_coil_in.set[0]
            && !m_coil_in.rst[0] && !m_coil_in.out_en[0] |=> m_bank_out[0] != $past(m_bank_out[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle coil did not invert");

    property p_tmr_stat;
        r.phase == LSB_ST_RUN |=> tmr_stat_out[0] == ($past(r.tcur[0]) >= $past(tpre[0]));
    endproperty
    a_tmr_stat: assert property (p_tmr_stat) else $error("timer status wrong");

    property p_tmr_off;
        // status lags the preset by a cycle, so it is held against the preset of that cycle
        scan_run && !tmr_en_in[0] |=> r.tcur[0] == 16'h0
            ##1 (tmr_stat_out[0] == ($past(tpre[0]) == 16'h0) || $past(scan_in));
    endproperty
    a_tmr_off: assert property (p_tmr_off) else $error("disabled timer not cleared");

    property p_cnt_stat;
        // the reset cycle itself forces status low, so it starts no check
        !sys_rst_in |=> cnt_stat_out[0] == ($past(r.ccur[0]) >= $past(cpre[0]));
    endproperty
    a_cnt_stat: assert property (p_cnt_stat) else $error("counter status wrong");

    property p_cnt_up;
        scan_run && cnt_in[0] && !r.cin_prev[0] && !cnt_rst_in[0] && !cnt_dir_in[0] && r.ccur[0] != 16'hFFFF
            |=> r.ccur[0] == $past(r.ccur[0]) + 16'h1;
    endproperty
    a_cnt_up: assert property (p_cnt_up) else $error("counter did not step up");

    property p_cnt_hold;
        scan_run && !(cnt_in[0] && !r.cin_prev[0]) && !cnt_rst_in[0] |=> $stable(r.ccur[0]);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without an input rise");

    property p_cnt_rst;
        scan_run && cnt_rst_in[0] |=> r.ccur[0] == 16'h0;
    endproperty
    a_cnt_rst: assert property (p_cnt_rst) else $error("counter reset ignored");

    property p_first;
        r.phase == LSB_ST_RESTORE && !sys_rst_in |=> m_bank_out[`LSB_FS_BIT] && r.fs_pend;
    endproperty
    a_first: assert property (p_first) else $error("first-scan flag not raised");

    property p_n_clear;
        $past(sys_rst_in) |-> n_bank_out == 63'h0;
    endproperty
    a_n_clear: assert property (p_n_clear) else $error("second bank not cleared");

    property p_thermo;
        scan_run |=> m_bank_out[`LSB_THERMO_BIT +: 4] == $past(thermo_err_in);
    endproperty
    a_thermo: assert property (p_thermo) else $error("thermo flags not updated");

    property p_clamp;
        tpre[0] <= PRESET_MAX && cpre[0] <= PRESET_MAX;
    endproperty
    a_clamp: assert property (p_clamp) else $error("preset exceeds limit");

    property p_blink;
        $changed(r.blink) |-> $past(r.bdiv) == BLINK_HALF_CYC - 32'h1;
    endproperty
    a_blink: assert property (p_blink) else $error("blink toggled off its period");

    // the restore step is the only place where the kept image enters the bank
    property p_keep;
        r.phase == LSB_ST_RESTORE && !sys_rst_in && keep_opt_in
            |=> m_bank_out[47:0] == $past(nv_image_in[47:0]);
    endproperty
    a_keep: assert property (p_keep) else $error("retained bits not restored");

    property p_no_keep;
        r.phase == LSB_ST_RESTORE && !sys_rst_in && !keep_opt_in |=> m_bank_out[47:0] == 48'h0;
    endproperty
    a_no_keep: assert property (p_no_keep) else $error("bank not cleared without retention");

    property p_summer;
        scan_run && summer_in != r.summer_prev |=> m_bank_out[`LSB_SUMMER_BIT] == $past(summer_in);
    endproperty
    a_summer: assert property (p_summer) else $error("seasonal flag not updated");

    property p_blink_copy;
        scan_run |=> m_bank_out[`LSB_BLINK_BIT] == $past(r.blink);
    endproperty
    a_blink_copy: assert property (p_blink_copy) else $error("blink flag not copied");

    // between scans neither bank and no rising one-shot may move
    property p_quiet;
        r.phase == LSB_ST_RUN && !scan_in |=> $stable(m_bank_out) && $stable(n_bank_out) && $stable(rise_out);
    endproperty
    a_quiet: assert property (p_quiet) else $error("bits moved outside a scan");

    c_toggle: cover property (scan_run && m_coil_in.tgl[0] && !r.eprev[0][2][0]);
    c_cnt_hit: cover property (scan_run && !cnt_stat_out[0] ##1 cnt_stat_out[0]);
    c_fall: cover property (fall_out[0]);
    c_tmr_done: cover property ($rose(tmr_stat_out[0]) && tmr_en_in[0]);
    c_rise: cover property (rise_out[0]);

endmodule

// ===== lsb_ladder_model.sv
`timescale 1ns/1ps

module lsb_ladder_model #(
    parameter int GAP = 3
) (
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    output logic      scan_out
);
    logic [7:0] cnt;

    // evenly spaced scans, so the program side can move its contacts between them
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cnt      <= 8'h00;
            scan_out <= 1'h0;
        end else begin
            scan_out <= (cnt == 8'(GAP - 1));
            cnt      <= (cnt == 8'(GAP - 1)) ? 8'h00 : cnt + 8'h01;
        end
    end
endmodule

// ===== lsb_scan_bits_bench.sv
`timescale 1ns/1ps

module lsb_scan_bits_bench
    import lsb_pkg::*;
;
    logic                mclk_in, sys_rst_in, scan_in, keep_opt_in, summer_in;
    lsb_bus_t            bus;
    logic [31:0]         rdata;
    logic [62:0]         nv_image, m_bank, n_bank;
    lsb_coil_t           m_coil, n_coil;
    logic [15:0]         os_in, rise, fall;
    logic [30:0]         tmr_en, cnt_in, cnt_dir, cnt_rst, tmr_stat, cnt_stat;
    logic [7:0][15:0]    ext_val;
    logic [3:0]          thermo_err;
    int                  miscompares, compares;

    // short blink and tick counts keep the run brief
    lsb_scan_bits #(.BLINK_HALF_CYC(32'h8), .TICK_CYC(32'h4)) u_dut (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus_in(bus), .rdata_out(rdata),
        .scan_in(scan_in), .keep_opt_in(keep_opt_in), .nv_image_in(nv_image),
        .m_coil_in(m_coil), .n_coil_in(n_coil), .os_in(os_in), .rise_out(rise), .fall_out(fall),
        .tmr_en_in(tmr_en), .cnt_in(cnt_in), .cnt_dir_in(cnt_dir), .cnt_rst_in(cnt_rst),
        .ext_val_in(ext_val), .summer_in(summer_in), .thermo_err_in(thermo_err),
        .m_bank_out(m_bank), .n_bank_out(n_bank), .tmr_stat_out(tmr_stat), .cnt_stat_out(cnt_stat));

    lsb_ladder_model u_prog (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scan_out(scan_in));

    // free running 100 mhz clock
    initial begin
        mclk_in = 1'h0;
        forever #5 mclk_in = ~mclk_in;
    end

    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            miscompares++;
        end
    endtask

    task end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // returns just after the next scan edge; a stuck scan ends the run
    task scan();
        int i;
        i = 0;
        @(posedge mclk_in); #1;
        while (scan_in !== 1'h1 && i < 20) begin
            @(posedge mclk_in); #1;
            i++;
        end
        if (i >= 20) begin
            miscompares++;
            end_of_test();
        end
        @(posedge mclk_in); #1;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge mclk_in);
        bus <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge mclk_in);
        bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
        @(posedge mclk_in);
        bus <= '0;
        #1 chk($sformatf("reg %h", a), rdata, exp);
    endtask

    task do_reset(input logic keep);
        sys_rst_in  <= 1'h1;
        keep_opt_in <= keep;
        repeat (8) @(posedge mclk_in);
        sys_rst_in <= 1'h0;
        @(posedge mclk_in); #1;
    endtask

    task t_restore();
        nv_image  <= 63'h0000_A5A5_5A5A_C3C3;
        summer_in <= 1'h1;
        do_reset(1'h1);
        chk("m restored", m_bank, 63'h0005_A5A5_5A5A_C3C3);
        chk("n cleared", n_bank, 63'h0);
        rdchk(12'h000, 32'h5A5A_C3C3);
        scan();
        chk("first scan", m_bank[48], 1'h0);
        chk("summer", m_bank[50], 1'h1);
        summer_in <= 1'h0;
        do_reset(1'h0);
        chk("m no keep", m_bank, 63'h0001_0000_0000_0000);
        summer_in <= 1'h1;
        scan();
        chk("summer on", m_bank[50], 1'h1);
        $display("restore done");
    endtask

    task t_oneshot();
        os_in <= 16'h0000;
        scan();
        os_in <= 16'hFFFF;
        scan();
        chk("rise", rise, 16'hFFFF);
        chk("no fall", fall, 16'h0);
        scan();
        chk("rise once", rise, 16'h0);
        os_in <= 16'h0000;
        scan();
        chk("fall", fall, 16'hFFFF);
        scan();
        chk("fall once", fall, 16'h0);
        $display("one-shot done");
    endtask

    task t_coils();
        m_coil.set[0] <= 1'h1;
        scan();
        m_coil.set[0] <= 1'h0;
        scan();
        chk("set held", m_bank[0], 1'h1);
        m_coil.rst[0] <= 1'h1;
        scan();
        m_coil.rst[0] <= 1'h0;
        scan();
        chk("reset held", m_bank[0], 1'h0);
        m_coil.tgl[0] <= 1'h1;
        scan();
        scan();
        chk("toggle on", m_bank[0], 1'h1);
        m_coil.tgl[0] <= 1'h0;
        scan();
        m_coil.tgl[0] <= 1'h1;
        scan();
        chk("toggle off", m_bank[0], 1'h0);
        n_coil.out_en  <= 63'h4000_0000_0000_0001;
        n_coil.out_val <= 63'h4000_0000_0000_0001;
        scan();
        chk("n coils", n_bank, 63'h4000_0000_0000_0001);
        rdchk(12'h00C, 32'h4000_0000);
        n_coil.out_en <= 63'h0;
        n_coil.rst[0] <= 1'h1;
        scan();
        chk("n reset", n_bank[0], 1'h0);
        do_reset(1'h0);
        chk("n after reset", n_bank, 63'h0);
        $display("coils done");
    endtask

    // one counting input rise per call, input held high afterwards
    task pulse();
        cnt_in[0] <= 1'h0;
        scan();
        cnt_in[0] <= 1'h1;
        scan();
    endtask

    task t_counter();
        wr(12'h200, 32'h0000_0002);
        pulse();
        scan();
        rdchk(12'h380, 32'h1);
        chk("cnt below", cnt_stat[0], 1'h0);
        pulse();
        rdchk(12'h380, 32'h2);
        chk("cnt reached", cnt_stat[0], 1'h1);
        cnt_dir[0] <= 1'h1;
        pulse();
        rdchk(12'h380, 32'h1);
        cnt_rst[0] <= 1'h1;
        scan();
        cnt_rst[0] <= 1'h0;
        rdchk(12'h380, 32'h0);
        cnt_dir[0] <= 1'h0;
        ext_val[0] <= 16'h0001;
        wr(12'h200, 32'h0003_0005);
        pulse();
        rdchk(12'h014, 32'h7FFF_FFFF);
        $display("counter done");
    endtask

    task t_timer();
        wr(12'h100, 32'h0000_0002);
        tmr_en[0] <= 1'h1;
        scan();
        @(posedge mclk_in); #1;
        chk("tmr below", tmr_stat[0], 1'h0);
        repeat (10) scan();
        chk("tmr reached", tmr_stat[0], 1'h1);
        rdchk(12'h300, 32'h2);
        tmr_en[0] <= 1'h0;
        scan();
        wr(12'h300, 32'h0000_1234);
        rdchk(12'h300, 32'h0);
        chk("tmr off", tmr_stat[0], 1'h0);
        $display("timer done");
    endtask

    task t_thermo();
        logic [5:0] seen;
        thermo_err <= 4'h5;
        scan();
        chk("thermo 5", m_bank[54:51], 4'h5);
        thermo_err <= 4'hA;
        scan();
        chk("thermo A", m_bank[54:51], 4'hA);
        // six scans span more than one blink half period, so both levels must show
        for (int k = 0; k < 6; k++) begin
            scan();
            seen[k] = m_bank[49];
        end
        chk("blink both", {62'h0, |seen, &seen}, 64'h2);
        rdchk(12'h7FC, 32'h0);
        $display("thermo done");
    endtask

    // every input driven here has a value at time zero, then the scenarios run in turn
    initial begin
        miscompares = 0;
        compares    = 0;
        sys_rst_in  = 1'h1;
        keep_opt_in = 1'h0;
        summer_in   = 1'h0;
        bus         = '0;
        nv_image    = '0;
        m_coil      = '0;
        n_coil      = '0;
        os_in       = '0;
        tmr_en      = '0;
        cnt_in      = '0;
        cnt_dir     = '0;
        cnt_rst     = '0;
        ext_val     = '0;
        thermo_err  = 4'h0;
        t_restore();
        t_oneshot();
        t_coils();
        t_counter();
        t_timer();
        t_thermo();
        end_of_test();
    end
endmodule
